/* rtl/pmic_fault_supervisor_regs.svh */
// register map, field positions, reset values and timing of the fault supervisor
`ifndef PMIC_FAULT_SUPERVISOR_REGS_SVH
`define PMIC_FAULT_SUPERVISOR_REGS_SVH

`define ADDR_SHORT_FLAGS_A 8'h5c
`define ADDR_SHORT_FLAGS_B 8'h5d
`define ADDR_COUNTDOWN_CFG 8'h5e
`define ADDR_CHECK_CFG 8'h5f
`define ADDR_CONVERTER_CFG 8'h61
`define ADDR_MISC_CFG 8'h68

`define RST_COUNTDOWN 5'h00
`define RST_CHECK_CFG 7'h00
`define RST_CONVERTER_CFG 8'h00
`define RST_MISC_CFG 8'h12

// flag vector order: core_one, core_two, io, dac, usb_low, usb_mid, usb_high, aux, card
`define FLAG_COUNT 9
`define FLAG_IO 2
`define FLAG_DAC 3
`define FLAG_USB_LOW 4
`define FLAG_USB_MID 5
`define FLAG_USB_HIGH 6
`define FLAG_AUX 7
`define FLAG_CARD 8
`define FLAGS_A_AUX_BIT 1
`define FLAGS_A_CARD_BIT 4

`define CHK_CHAN_A_BIT 6
`define CHK_LIVE_BIT 3
`define CHK_ENABLE_BIT 0
`define CONV_FAST_DEGATE_BIT 0
`define CONV_SLOW_DEGATE_BIT 1

// pin synchroniser vector positions
`define SYN_WAITON_N 9
`define SYN_SECURE 10
`define SYN_POR_N 11
`define SYN_CARD0 12
`define SYN_BAT_LOW 14
`define SYN_SLOW_CLK 15
`define SYN_WIDTH 16

`define SLOW_CLK_HZ 32768
`define CHECK_MIN_S 3

`endif

/* rtl/pmic_fault_supervisor_pkg.sv */
// types shared by the fault supervisor modules
package pmic_fault_supervisor_pkg;
   typedef enum logic [1:0] {CHECK_IDLE, CHECK_COUNT, CHECK_FIRED} check_state_t;
   typedef logic [7:0] reg_byte_t;
endpackage

/* rtl/supervisor_timer_if.sv */
// signals between the register side and the one-second timer
`timescale 1ns/100ps
interface supervisor_timer_if;
   logic slow_clk;
   logic second_tick;
   logic check_on;
   logic [1:0] check_delay;
   logic irq_pending;
   logic check_expired;
   modport timer (input slow_clk, check_on, check_delay, irq_pending,
                  output second_tick, check_expired);
   modport regs (output slow_clk, check_on, check_delay, irq_pending,
                 input second_tick, check_expired);
endinterface

/* rtl/supervisor_timer.sv */
// one-second prescaler and power button interrupt check timer
`timescale 1ns/100ps
`include "pmic_fault_supervisor_regs.svh"
module supervisor_timer #(
   parameter int SLOW_HZ = `SLOW_CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic rst,
   supervisor_timer_if.timer tif
);
   import pmic_fault_supervisor_pkg::*;

   // ****************************************************
   // prescaler
   // ****************************************************
   logic slow_prev, next_slow_prev;
   logic [15:0] edge_count, next_edge_count;
   logic tick, next_tick;
   check_state_t state, next_state;
   logic [2:0] secs, next_secs;
   logic fire, next_fire;

   always_comb begin
      next_slow_prev = tif.slow_clk;
      next_edge_count = edge_count;
      next_tick = 1'b0;
      if (tif.slow_clk && !slow_prev) begin
         if (edge_count == 16'(SLOW_HZ - 1)) begin
            next_edge_count = 16'h0000;
            next_tick = 1'b1;
         end else begin
            next_edge_count = edge_count + 16'h0001;
         end
      end
   end

   // ****************************************************
   // interrupt check
   // ****************************************************
   always_comb begin
      next_state = state;
      next_secs = secs;
      next_fire = 1'b0;
      if (!tif.check_on || !tif.irq_pending) begin
         next_state = CHECK_IDLE;
         next_secs = 3'h0;
      end else begin
         unique case (state)
            CHECK_IDLE: begin
               next_state = CHECK_COUNT;
               next_secs = 3'h0;
            end
            CHECK_COUNT: begin
               if (tick) begin
                  next_secs = secs + 3'h1;
                  // delay code plus the three second base
                  if (secs + 3'h1 == 3'(`CHECK_MIN_S) + {1'b0, tif.check_delay}) begin
                     next_fire = 1'b1;
                     next_state = CHECK_FIRED;
                  end
               end
            end
            CHECK_FIRED: next_state = CHECK_FIRED;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slow_prev <= 1'b0;
         edge_count <= 16'h0000;
         tick <= 1'b0;
         state <= CHECK_IDLE;
         secs <= 3'h0;
         fire <= 1'b0;
      end else begin
         slow_prev <= next_slow_prev;
         edge_count <= next_edge_count;
         tick <= next_tick;
         state <= next_state;
         secs <= next_secs;
         fire <= next_fire;
      end
   end

   assign tif.second_tick = tick;
   assign tif.check_expired = fire;

   property p_fire_needs_pending;
      @(posedge clk_sys) disable iff (rst)
      fire |-> $past(tif.check_on) && $past(tif.irq_pending) && $past(state == CHECK_COUNT);
   endproperty
   a_fire_needs_pending: assert property (p_fire_needs_pending)
      else $error("check fired without a pending enabled interrupt");

   c_check_fired: cover property (@(posedge clk_sys) disable iff (rst) fire);
endmodule

/* rtl/pmic_fault_supervisor.sv */
// fault supervisor: short flags, fault_cutoff_enable, countdown watchdog and global config
`timescale 1ns/100ps
`include "pmic_fault_supervisor_regs.svh"
module pmic_fault_supervisor #(
   parameter int SLOW_HZ = `SLOW_CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output pmic_fault_supervisor_pkg::reg_byte_t reg_rdata,
   output logic reg_rvalid,
   input wire logic [8:0] short_detect_raw,
   input wire logic fault_cutoff_enable,
   input wire logic waiton_reset_n,
   input wire logic test_unlock_key,
   input wire logic secure_mode_pin,
   input wire logic power_on_reset_out_n,
   input wire logic power_button_irq,
   input wire logic [2:0] restart_on_sw_fault,
   input wire logic slow_clk_in,
   input wire logic [1:0] card_detect_pin,
   input wire logic regen_drive_low,
   input wire logic sysen_drive_low,
   input wire logic battery_low,
   input wire logic analog_manual_lower,
   input wire logic pm_fast_clk_gate,
   input wire logic pm_clk_enable,
   input wire logic pm_slow_clk_gate,
   output logic [3:0] regulator_sleep_req,
   output logic [1:0] regulator_off_req,
   output logic waiton_req,
   output logic system_reset_req,
   output logic auto_restart_req,
   output logic threshold_sel_chan_a,
   output logic [1:0] threshold_sel_chan_b,
   output logic fast_clk_gate,
   output logic clk_enable_out,
   output logic slow_clk_gate,
   output logic [1:0] card_present,
   output logic regen_pullup_en,
   output logic sysen_pullup_en,
   output logic analog_supply_lower,
   output logic fast_clk_drive_strength,
   output logic [1:0] hot_die_temp_sel
);
   import pmic_fault_supervisor_pkg::*;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic [`SYN_WIDTH-1:0] pins, s1, s2, s3, filt;
   logic [`SYN_WIDTH-1:0] next_s1, next_s2, next_s3, next_filt;

   assign pins = {slow_clk_in, battery_low, card_detect_pin, power_on_reset_out_n,
                  secure_mode_pin, waiton_reset_n, short_detect_raw};

   always_comb begin
      next_s1 = pins;
      next_s2 = s1;
      next_s3 = s2;
      // a change is taken once the second and third stages agree
      next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
         filt <= next_filt;
      end
   end

   logic [`FLAG_COUNT-1:0] live;
   logic waiton_n_f, secure_f, por_n_f;
   assign live = filt[`FLAG_COUNT-1:0];
   assign waiton_n_f = filt[`SYN_WAITON_N];
   assign secure_f = filt[`SYN_SECURE];
   assign por_n_f = filt[`SYN_POR_N];

   // ****************************************************
   // timer
   // ****************************************************
   supervisor_timer_if tif ();
   logic [6:0] check_cfg, next_check_cfg;

   assign tif.slow_clk = filt[`SYN_SLOW_CLK];
   assign tif.check_on = check_cfg[`CHK_ENABLE_BIT];
   assign tif.check_delay = check_cfg[2:1];
   assign tif.irq_pending = power_button_irq;

   supervisor_timer #(.SLOW_HZ(SLOW_HZ)) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .tif(tif)
   );

   // ****************************************************
   // registers
   // ****************************************************
   logic [`FLAG_COUNT-1:0] flags, next_flags, flag_clr;
   logic [4:0] countdown, next_countdown;
   logic [7:0] conv_cfg, next_conv_cfg;
   logic [7:0] misc_cfg, next_misc_cfg;
   logic wr_a, wr_b, wr_cd, wr_chk, wr_conv, wr_misc;

   assign wr_a = reg_write && reg_addr == `ADDR_SHORT_FLAGS_A;
   assign wr_b = reg_write && reg_addr == `ADDR_SHORT_FLAGS_B;
   assign wr_cd = reg_write && reg_addr == `ADDR_COUNTDOWN_CFG;
   assign wr_chk = reg_write && reg_addr == `ADDR_CHECK_CFG;
   assign wr_conv = reg_write && reg_addr == `ADDR_CONVERTER_CFG;
   assign wr_misc = reg_write && reg_addr == `ADDR_MISC_CFG;

   always_comb begin
      // writing zero clears a flag; a short in the same cycle wins
      flag_clr = '0;
      if (wr_b) begin
         flag_clr[`FLAG_USB_HIGH:0] = ~reg_wdata[7:1];
      end
      if (wr_a) begin
         flag_clr[`FLAG_AUX] = ~reg_wdata[`FLAGS_A_AUX_BIT];
         flag_clr[`FLAG_CARD] = ~reg_wdata[`FLAGS_A_CARD_BIT];
      end
      next_flags = (flags & ~flag_clr) | live;

      next_countdown = countdown;
      if (wr_cd) begin
         next_countdown = reg_wdata[4:0];
      end else if (tif.second_tick && countdown > 5'h01) begin
         next_countdown = countdown - 5'h01;
      end

      next_check_cfg = check_cfg;
      if (wr_chk && test_unlock_key) begin
         next_check_cfg = reg_wdata[6:0];
      end

      if (!waiton_n_f) begin
         next_countdown = `RST_COUNTDOWN;
         next_check_cfg[3:0] = 4'(`RST_CHECK_CFG);
      end

      next_conv_cfg = conv_cfg;
      if (wr_conv) begin
         next_conv_cfg[7:2] = reg_wdata[7:2];
         if (secure_f) begin
            next_conv_cfg[1:0] = reg_wdata[1:0];
         end
      end
      if (!por_n_f) begin
         next_conv_cfg[1:0] = 2'h0;
      end

      next_misc_cfg = wr_misc ? reg_wdata : misc_cfg;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flags <= '0;
         countdown <= `RST_COUNTDOWN;
         check_cfg <= `RST_CHECK_CFG;
         conv_cfg <= `RST_CONVERTER_CFG;
         misc_cfg <= `RST_MISC_CFG;
      end else begin
         flags <= next_flags;
         countdown <= next_countdown;
         check_cfg <= next_check_cfg;
         conv_cfg <= next_conv_cfg;
         misc_cfg <= next_misc_cfg;
      end
   end

   // ****************************************************
   // read path
   // ****************************************************
   logic [`FLAG_COUNT-1:0] shown;
   reg_byte_t next_rdata;

   always_comb begin
      shown = check_cfg[`CHK_LIVE_BIT] ? live : flags;
      unique case (reg_addr)
         `ADDR_SHORT_FLAGS_A: next_rdata = {3'h0, shown[`FLAG_CARD], 2'h0,
                                            shown[`FLAG_AUX], 1'b0};
         `ADDR_SHORT_FLAGS_B: next_rdata = {shown[`FLAG_USB_HIGH:0], 1'b0};
         `ADDR_COUNTDOWN_CFG: next_rdata = {3'h0, countdown};
         `ADDR_CHECK_CFG: next_rdata = {1'b0, check_cfg};
         `ADDR_CONVERTER_CFG: next_rdata = conv_cfg;
         `ADDR_MISC_CFG: next_rdata = misc_cfg;
         default: next_rdata = 8'h00;
      endcase
      if (!reg_read) begin
         next_rdata = reg_rdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         reg_rvalid <= reg_read;
      end
   end

   // ****************************************************
   // reactions and outputs
   // ****************************************************
   logic [3:0] next_sleep;
   logic [1:0] next_off, next_card;
   logic next_waiton, next_fast_gate, next_clk_en, next_slow_gate;
   logic next_regen_pu, next_sysen_pu, next_lower;

   always_comb begin
      next_sleep = {4{fault_cutoff_enable}} & {flags[`FLAG_CARD], flags[`FLAG_AUX],
                   flags[`FLAG_DAC], flags[`FLAG_USB_HIGH]};
      next_off = {2{fault_cutoff_enable}} &
                 {flags[`FLAG_USB_MID], flags[`FLAG_USB_LOW]};
      next_waiton = (fault_cutoff_enable && |flags[`FLAG_IO:0])
                    || countdown == 5'h01;
      next_fast_gate = conv_cfg[`CONV_FAST_DEGATE_BIT] ? 1'b0 : pm_fast_clk_gate;
      next_clk_en = conv_cfg[`CONV_FAST_DEGATE_BIT] ? 1'b1 : pm_clk_enable;
      next_slow_gate = conv_cfg[`CONV_SLOW_DEGATE_BIT] ? 1'b0 : pm_slow_clk_gate;
      next_card = filt[`SYN_CARD0+1:`SYN_CARD0] ^ conv_cfg[7:6];
      next_regen_pu = !conv_cfg[5] && !regen_drive_low;
      next_sysen_pu = !conv_cfg[4] && !sysen_drive_low;
      next_lower = misc_cfg[5] ? filt[`SYN_BAT_LOW] : analog_manual_lower;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regulator_sleep_req <= 4'h0;
         regulator_off_req <= 2'h0;
         waiton_req <= 1'b0;
         system_reset_req <= 1'b0;
         auto_restart_req <= 1'b0;
         threshold_sel_chan_a <= 1'b0;
         threshold_sel_chan_b <= 2'h0;
         fast_clk_gate <= 1'b0;
         clk_enable_out <= 1'b0;
         slow_clk_gate <= 1'b0;
         card_present <= 2'h0;
         regen_pullup_en <= 1'b0;
         sysen_pullup_en <= 1'b0;
         analog_supply_lower <= 1'b0;
         fast_clk_drive_strength <= 1'b0;
         hot_die_temp_sel <= 2'h0;
      end else begin
         regulator_sleep_req <= next_sleep;
         regulator_off_req <= next_off;
         waiton_req <= next_waiton;
         system_reset_req <= tif.check_expired;
         auto_restart_req <= tif.check_expired && |restart_on_sw_fault;
         threshold_sel_chan_a <= check_cfg[`CHK_CHAN_A_BIT];
         threshold_sel_chan_b <= check_cfg[5:4];
         fast_clk_gate <= next_fast_gate;
         clk_enable_out <= next_clk_en;
         slow_clk_gate <= next_slow_gate;
         card_present <= next_card;
         regen_pullup_en <= next_regen_pu;
         sysen_pullup_en <= next_sysen_pu;
         analog_supply_lower <= next_lower;
         fast_clk_drive_strength <= misc_cfg[4];
         hot_die_temp_sel <= misc_cfg[7:6];
      end
   end

   // ****************************************************
   // assertions
   // ****************************************************
   property p_flag_sticky;
      !reg_write |=> (flags & $past(flags)) == $past(flags);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("short flag dropped without a write");

   property p_live_read;
      reg_read && reg_addr == `ADDR_SHORT_FLAGS_B && check_cfg[`CHK_LIVE_BIT]
         |=> reg_rvalid && reg_rdata == {$past(live[`FLAG_USB_HIGH:0]), 1'b0};
   endproperty
   a_live_read: assert property (p_live_read)
      else $error("live select read returned latched flags");

   property p_sleep;
      fault_cutoff_enable && flags[`FLAG_CARD] |=> regulator_sleep_req[3];
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("card regulator short not put to sleep");

   property p_off;
      regulator_off_req[0] |-> $past(fault_cutoff_enable) && $past(flags[`FLAG_USB_LOW]);
   endproperty
   a_off: assert property (p_off)
      else $error("usb low off request without cause");

   property p_core_waiton;
      fault_cutoff_enable && flags[0] |=> waiton_req;
   endproperty
   a_core_waiton: assert property (p_core_waiton)
      else $error("core short did not force wait-on");

   property p_zero_holds;
      countdown == 5'h00 && !wr_cd && !fault_cutoff_enable |=> countdown == 5'h00 && !waiton_req;
   endproperty
   a_zero_holds: assert property (p_zero_holds)
      else $error("disabled countdown moved");

   property p_one_waiton;
      countdown == 5'h01 |=> waiton_req;
   endproperty
   a_one_waiton: assert property (p_one_waiton)
      else $error("countdown of one did not force wait-on");

   property p_decrement;
      tif.second_tick && countdown > 5'h01 && !wr_cd && waiton_n_f
         |=> countdown == $past(countdown) - 5'h01;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("countdown did not decrement on the tick");

   property p_waiton_clear;
      !waiton_n_f |=> countdown == 5'h00 && check_cfg[3:0] == 4'h0;
   endproperty
   a_waiton_clear: assert property (p_waiton_clear)
      else $error("fields not cleared by wait-on reset");

   property p_key_lock;
      wr_chk && !test_unlock_key && waiton_n_f |=> $stable(check_cfg);
   endproperty
   a_key_lock: assert property (p_key_lock)
      else $error("check register written while locked");

   property p_degate_secure;
      wr_conv && !secure_f && por_n_f |=> $stable(conv_cfg[1:0]);
   endproperty
   a_degate_secure: assert property (p_degate_secure)
      else $error("de-gate bits written without secure mode");

   property p_clk_en_held;
      conv_cfg[`CONV_FAST_DEGATE_BIT] |=> clk_enable_out && !fast_clk_gate;
   endproperty
   a_clk_en_held: assert property (p_clk_en_held)
      else $error("clock enable not held with fast de-gate set");

   c_cutoff_sleep: cover property (fault_cutoff_enable && |regulator_sleep_req);
   c_countdown_expire: cover property (countdown == 5'h02 ##1 countdown == 5'h01);
   c_live_read: cover property (reg_read && check_cfg[`CHK_LIVE_BIT]);
   c_reset_restart: cover property (auto_restart_req);
endmodule

/* tb/host_model.sv */
// host software and slow clock model driving the register port
`timescale 1ns/100ps
module host_model (
   input wire logic clk_sys,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   output logic reg_write = 1'b0,
   output logic reg_read = 1'b0,
   output logic slow_clk_in = 1'b0
);
   // free-running 32 kHz stand-in, 8 system cycles per level
   always begin
      repeat (8) @(posedge clk_sys);
      #1;
      slow_clk_in = ~slow_clk_in;
   end
   // strobes held from just after one edge up to the sampling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_read = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

/* tb/pmic_fault_supervisor_tb.sv */
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
module pmic_fault_supervisor_tb;
   import pmic_fault_supervisor_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata;
   logic reg_write, reg_read, slow_clk_in, reg_rvalid, waiton_req;
   reg_byte_t reg_rdata;
   logic system_reset_req, auto_restart_req, threshold_sel_chan_a, clk_enable_out;
   logic regen_pullup_en, sysen_pullup_en;
   logic fast_clk_gate, slow_clk_gate, analog_supply_lower, fast_clk_drive_strength;
   logic [1:0] threshold_sel_chan_b, regulator_off_req, card_present, hot_die_temp_sel;
   logic [3:0] regulator_sleep_req;
   logic [8:0] short_detect_raw = 9'h000;
   logic fault_cutoff_enable = 1'b0;
   logic waiton_reset_n = 1'b0;
   logic test_unlock_key = 1'b0;
   logic secure_mode_pin = 1'b0;
   logic power_on_reset_out_n = 1'b0;
   logic power_button_irq = 1'b0;
   logic [2:0] restart_on_sw_fault = 3'h0;
   logic [1:0] card_detect_pin = 2'h0;
   logic [6:0] rnd = 7'h00;
   int seed = 24;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   logic [7:0] exp_q[$];
   logic [7:0] addrs[7] = '{8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h61, 8'h68, 8'h60};
   logic [7:0] rstv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h00};

   pmic_fault_supervisor #(.SLOW_HZ(4)) i_pmic_fault_supervisor (
      .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
      .short_detect_raw, .fault_cutoff_enable, .waiton_reset_n, .test_unlock_key,
      .secure_mode_pin, .power_on_reset_out_n, .power_button_irq, .restart_on_sw_fault,
      .slow_clk_in, .card_detect_pin, .regen_drive_low(rnd[0]), .sysen_drive_low(rnd[1]),
      .battery_low(rnd[2]), .analog_manual_lower(rnd[3]), .pm_fast_clk_gate(rnd[4]),
      .pm_clk_enable(rnd[5]), .pm_slow_clk_gate(rnd[6]), .regulator_sleep_req,
      .regulator_off_req, .waiton_req, .system_reset_req, .auto_restart_req,
      .threshold_sel_chan_a, .threshold_sel_chan_b, .fast_clk_gate, .clk_enable_out,
      .slow_clk_gate, .card_present, .regen_pullup_en, .sysen_pullup_en,
      .analog_supply_lower, .fast_clk_drive_strength, .hot_die_temp_sel);
   host_model i_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .slow_clk_in);

   always #2 clk_sys = ~clk_sys;

   task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_model.rd(a);
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // read answers are matched against the oldest note
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0)
            check("unexpected read", 8'h00, 8'hff);
         else
            check("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      rnd = 7'($random(seed));
      step(12);
      rst = 1'b0;
      waiton_reset_n = 1'b1;
      power_on_reset_out_n = 1'b1;
      secure_mode_pin = 1'b1;
      card_detect_pin = 2'b01;
      step(5);
      foreach (addrs[i]) rd(addrs[i], rstv[i]);
      $display("done reset values");
      i_host_model.wr(8'h61, 8'h81);
      step(6);
      check("card_present", 8'h03, {6'h0, card_present});
      check("regen_pullup_en", {7'h0, ~rnd[0]}, {7'h0, regen_pullup_en});
      check("clk_enable_out", 8'h01, {7'h0, clk_enable_out});
      check("fast_clk_gate", 8'h00, {7'h0, fast_clk_gate});
      check("slow_clk_gate", {7'h0, rnd[6]}, {7'h0, slow_clk_gate});
      check("analog_supply_lower", {7'h0, rnd[3]}, {7'h0, analog_supply_lower});
      check("misc outputs", 8'h01, {5'h0, hot_die_temp_sel, fast_clk_drive_strength});
      i_host_model.wr(8'h68, 8'he0);
      step(3);
      check("analog_supply_lower", {7'h0, rnd[2]}, {7'h0, analog_supply_lower});
      check("misc outputs", 8'h06, {5'h0, hot_die_temp_sel, fast_clk_drive_strength});
      rd(8'h68, 8'he0);
      secure_mode_pin = 1'b0;
      // the secure pin passes the synchroniser before the write may rely on it
      step(5);
      i_host_model.wr(8'h61, 8'h30);
      rd(8'h61, 8'h31);
      check("sysen_pullup_en", 8'h00, {7'h0, sysen_pullup_en});
      power_on_reset_out_n = 1'b0;
      step(8);
      power_on_reset_out_n = 1'b1;
      step(5);
      rd(8'h61, 8'h30);
      $display("done global config");
      short_detect_raw = 9'h1ff;
      step(6);
      short_detect_raw = 9'h000;
      step(8);
      check("regulator_sleep_req", 8'h00, {4'h0, regulator_sleep_req});
      fault_cutoff_enable = 1'b1;
      step(3);
      check("regulator_sleep_req", 8'h0f, {4'h0, regulator_sleep_req});
      check("regulator_off_req", 8'h03, {6'h0, regulator_off_req});
      check("waiton_req", 8'h01, {7'h0, waiton_req});
      rd(8'h5d, 8'hfe);
      fault_cutoff_enable = 1'b0;
      i_host_model.wr(8'h5d, 8'h00);
      rd(8'h5d, 8'h00);
      rd(8'h5c, 8'h12);
      i_host_model.wr(8'h5c, 8'h00);
      $display("done short flags");
      test_unlock_key = 1'b1;
      i_host_model.wr(8'h5f, 8'h08);
      short_detect_raw = 9'h004;
      step(8);
      short_detect_raw = 9'h000;
      step(8);
      rd(8'h5d, 8'h00);
      test_unlock_key = 1'b0;
      i_host_model.wr(8'h5f, 8'h00);
      rd(8'h5f, 8'h08);
      test_unlock_key = 1'b1;
      i_host_model.wr(8'h5f, 8'h00);
      rd(8'h5d, 8'h08);
      i_host_model.wr(8'h5d, 8'h00);
      $display("done live select");
      i_host_model.wr(8'h5e, 8'h02);
      n = 0;
      while (waiton_req !== 1'b1 && n < 300) begin
         step(1);
         n++;
      end
      check("waiton_req", 8'h01, {7'h0, waiton_req});
      rd(8'h5e, 8'h01);
      i_host_model.wr(8'h5e, 8'h00);
      step(200);
      check("waiton_req", 8'h00, {7'h0, waiton_req});
      $display("done countdown");
      restart_on_sw_fault = 3'b010;
      i_host_model.wr(8'h5f, 8'h01);
      power_button_irq = 1'b1;
      n = 0;
      while (system_reset_req !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
      check("system_reset_req", 8'h01, {7'h0, system_reset_req});
      check("auto_restart_req", 8'h01, {7'h0, auto_restart_req});
      check("check delay window", 8'h01, {7'h0, n > 110 && n < 210});
      power_button_irq = 1'b0;
      $display("done interrupt check");
      i_host_model.wr(8'h5f, 8'h7f);
      step(2);
      check("thresholds", 8'h07, {5'h0, threshold_sel_chan_a, threshold_sel_chan_b});
      waiton_reset_n = 1'b0;
      step(10);
      waiton_reset_n = 1'b1;
      step(6);
      rd(8'h5f, 8'h70);
      step(4);
      $display("done wait-on reset");
      give_verdict();
   end
endmodule
